// ---- audio_ctrl_pkg.sv ----
// constants, types and carriers shared by the sound-path control registers
// Function
// - with the polarity bit (6) of the interpolator control clear, left feeds channel 1 and right channel 2; set, polarity is inverted.
// - roll-off codes 0 and 1 at bits 5..4 pick the slow filter, codes 2 and 3 the fast one.
// - de-emphasis bits 3..1 pick none (0), 32 kHz (1), 44.1 kHz (2), 48 kHz (3), 96 kHz (4), and none for any higher code.
// - soft mute bit 0 ramps both channels down or up along a raised cosine, and resets to 0 in legacy mode and 1 in bus mode.
// - the left volume code comes from bits 15..8 of the volume register and sets the left channel attenuation.
// - the right volume code comes from bits 7..0 of the volume register and sets the right channel attenuation.
// - the interpolator control register is read/write and resets to 0x0020 in legacy mode and 0x0021 in bus mode.
package audio_ctrl_pkg;

	// register pointers as sent in the sub-address byte
	localparam logic [7:0] INTERP_CTRL_ADDR = 8'h00;
	localparam logic [7:0] VOLUME_ADDR = 8'h01;

	// field positions
	localparam int POLARITY_BIT = 6;
	localparam int ROLLOFF_MSB = 5;
	localparam int ROLLOFF_LSB = 4;
	localparam int DEEMPH_MSB = 3;
	localparam int DEEMPH_LSB = 1;
	localparam int SOFT_MUTE_BIT = 0;
	localparam int CTRL_USED_MSB = 6;
	localparam int LEFT_VOL_MSB = 15;
	localparam int LEFT_VOL_LSB = 8;
	localparam int RIGHT_VOL_MSB = 7;
	localparam int RIGHT_VOL_LSB = 0;

	// reset values
	localparam logic [15:0] CTRL_RESET_LEGACY = 16'h0020;
	localparam logic [15:0] CTRL_RESET_I2C = 16'h0021;
	localparam logic [15:0] VOLUME_RESET = 16'h0000;

	// upper five bits of the slave address, low two come from pins
	localparam logic [4:0] DEVICE_ADDR_BASE = 5'h0d;

	// timing counts
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [4:0] RAMP_STEPS = 5'h10;
	localparam int RAMP_STEP_CYCLES = 256;

	typedef enum logic [2:0] {
		DEEMPH_NONE = 3'h0,
		DEEMPH_32K = 3'h1,
		DEEMPH_44K1 = 3'h2,
		DEEMPH_48K = 3'h3,
		DEEMPH_96K = 3'h4
	} deemph_e;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ACK_ADDR = 9'h004,
		ST_SUB = 9'h008,
		ST_ACK_SUB = 9'h010,
		ST_WRITE = 9'h020,
		ST_ACK_WRITE = 9'h040,
		ST_READ = 9'h080,
		ST_READ_ACK = 9'h100
	} bus_state_e;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_pins_in_s;

	typedef struct packed {
		logic sda_out;
		logic sda_oe_n;
	} bus_pins_out_s;

	typedef struct packed {
		logic channel_polarity_invert;
		logic [1:0] filter_rolloff_select;
		logic rolloff_fast;
		deemph_e deemphasis_select;
		logic soft_mute;
		logic muted;
		logic [7:0] mute_gain;
		logic [7:0] left_volume_code;
		logic [7:0] right_volume_code;
	} sound_settings_s;

endpackage

// ---- pin_sync.sv ----
// two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_s;

	sync_state_s r;
	sync_state_s next_r;

	// first stage feeds only the second stage
	always_comb begin
		next_r = r;
		next_r.first = d;
		next_r.second = r.first;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.second;
endmodule

// ---- sound_ctrl_regs.sv ----
// bus-mode control port and the interpolator / volume registers
`timescale 1ns/100ps
module sound_ctrl_regs #(
	parameter int RAMP_STEP_CYCLES = audio_ctrl_pkg::RAMP_STEP_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input audio_ctrl_pkg::bus_pins_in_s bus_in,
	input wire logic [1:0] addr_select,
	input wire logic i2c_mode,
	output audio_ctrl_pkg::bus_pins_out_s bus_out,
	output audio_ctrl_pkg::sound_settings_s settings
);
	typedef struct packed {
		audio_ctrl_pkg::bus_state_e st;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [15:0] tx;
		logic [7:0] ptr;
		logic rw;
		logic byte_hi;
		logic [7:0] wr_hi;
		logic scl_prev;
		logic sda_prev;
		logic [6:0] ctrl;
		logic [15:0] volume;
		logic [1:0] boot_cnt;
		logic [4:0] ramp_idx;
		logic [15:0] ramp_div;
		audio_ctrl_pkg::bus_pins_out_s pins;
		audio_ctrl_pkg::sound_settings_s out;
	} state_s;

	localparam logic [15:0] RAMP_LAST = 16'(RAMP_STEP_CYCLES - 1);

	state_s r;
	state_s next_r;
	logic [4:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic mode_s;
	logic [6:0] dev_addr;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic wr_en;
	logic [15:0] wr_data;

	// pins and straps are asynchronous to clock
	pin_sync #(.WIDTH(5)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.d({bus_in.scl, bus_in.sda, i2c_mode, addr_select}),
		.q(pins_s)
	);

	assign scl_s = pins_s[4];
	assign sda_s = pins_s[3];
	assign mode_s = pins_s[2];
	assign dev_addr = {audio_ctrl_pkg::DEVICE_ADDR_BASE, pins_s[1:0]};

	// readback: unused control bits and unmapped pointers read as zero
	function automatic logic [15:0] read_word(input logic [7:0] ptr,
			input logic [6:0] ctrl, input logic [15:0] volume);
		logic [15:0] w;
		w = 16'h0000;
		if (ptr == audio_ctrl_pkg::INTERP_CTRL_ADDR) begin
			w = {9'h000, ctrl};
		end else if (ptr == audio_ctrl_pkg::VOLUME_ADDR) begin
			w = volume;
		end
		return w;
	endfunction

	// raised-cosine gain, index 0 is full gain and 16 is silence
	function automatic logic [7:0] cosine_gain(input logic [4:0] idx);
		logic [7:0] g;
		g = 8'h00;
		case (idx)
			5'h00: g = 8'hff;
			5'h01: g = 8'hfd;
			5'h02: g = 8'hf5;
			5'h03: g = 8'hea;
			5'h04: g = 8'hda;
			5'h05: g = 8'hc6;
			5'h06: g = 8'hb0;
			5'h07: g = 8'h98;
			5'h08: g = 8'h80;
			5'h09: g = 8'h67;
			5'h0a: g = 8'h4f;
			5'h0b: g = 8'h39;
			5'h0c: g = 8'h25;
			5'h0d: g = 8'h15;
			5'h0e: g = 8'h0a;
			5'h0f: g = 8'h02;
			default: g = 8'h00;
		endcase
		return g;
	endfunction

	// codes 5..7 fall back to no de-emphasis
	function automatic audio_ctrl_pkg::deemph_e decode_deemph(
			input logic [2:0] code);
		audio_ctrl_pkg::deemph_e d;
		d = audio_ctrl_pkg::DEEMPH_NONE;
		case (code)
			3'h1: d = audio_ctrl_pkg::DEEMPH_32K;
			3'h2: d = audio_ctrl_pkg::DEEMPH_44K1;
			3'h3: d = audio_ctrl_pkg::DEEMPH_48K;
			3'h4: d = audio_ctrl_pkg::DEEMPH_96K;
			default: d = audio_ctrl_pkg::DEEMPH_NONE;
		endcase
		return d;
	endfunction

	// bus engine, register writes, mode strap, mute ramp and outputs
	always_comb begin
		next_r = r;
		wr_en = 1'b0;
		wr_data = {r.wr_hi, r.shift};
		scl_rise = scl_s & ~r.scl_prev;
		scl_fall = ~scl_s & r.scl_prev;
		start_seen = r.scl_prev & scl_s & r.sda_prev & ~sda_s;
		stop_seen = r.scl_prev & scl_s & ~r.sda_prev & sda_s;
		next_r.scl_prev = scl_s;
		next_r.sda_prev = sda_s;

		if (scl_rise) begin
			next_r.shift = {r.shift[6:0], sda_s};
			next_r.bit_cnt = r.bit_cnt + 4'h1;
		end

		if (stop_seen) begin
			next_r.st = audio_ctrl_pkg::ST_IDLE;
			next_r.pins = '{sda_out: 1'b1, sda_oe_n: 1'b1};
		end else if (start_seen) begin
			// repeated start keeps the pointer for a following read
			next_r.st = audio_ctrl_pkg::ST_ADDR;
			next_r.bit_cnt = 4'h0;
			next_r.pins = '{sda_out: 1'b1, sda_oe_n: 1'b1};
		end else begin
			unique case (r.st)
				audio_ctrl_pkg::ST_IDLE: begin
				end
				audio_ctrl_pkg::ST_ADDR: begin
					if (scl_fall && r.bit_cnt == 4'h8) begin
						if (r.shift[7:1] == dev_addr) begin
							next_r.rw = r.shift[0];
							next_r.pins = '{sda_out: 1'b0, sda_oe_n: 1'b0};
							next_r.st = audio_ctrl_pkg::ST_ACK_ADDR;
						end else begin
							next_r.st = audio_ctrl_pkg::ST_IDLE;
						end
					end
				end
				audio_ctrl_pkg::ST_ACK_ADDR: begin
					if (scl_fall) begin
						next_r.bit_cnt = 4'h0;
						next_r.byte_hi = 1'b1;
						if (r.rw) begin
							next_r.tx = read_word(r.ptr, r.ctrl, r.volume);
							next_r.pins.sda_out = 1'b0;
							next_r.pins.sda_oe_n = next_r.tx[15];
							next_r.st = audio_ctrl_pkg::ST_READ;
						end else begin
							next_r.pins = '{sda_out: 1'b1, sda_oe_n: 1'b1};
							next_r.st = audio_ctrl_pkg::ST_SUB;
						end
					end
				end
				audio_ctrl_pkg::ST_SUB: begin
					if (scl_fall && r.bit_cnt == 4'h8) begin
						next_r.ptr = r.shift;
						next_r.pins = '{sda_out: 1'b0, sda_oe_n: 1'b0};
						next_r.st = audio_ctrl_pkg::ST_ACK_SUB;
					end
				end
				audio_ctrl_pkg::ST_ACK_SUB, audio_ctrl_pkg::ST_ACK_WRITE: begin
					if (scl_fall) begin
						next_r.bit_cnt = 4'h0;
						next_r.pins = '{sda_out: 1'b1, sda_oe_n: 1'b1};
						next_r.st = audio_ctrl_pkg::ST_WRITE;
					end
				end
				audio_ctrl_pkg::ST_WRITE: begin
					// high byte first; the word lands on its low byte
					if (scl_fall && r.bit_cnt == 4'h8) begin
						next_r.pins = '{sda_out: 1'b0, sda_oe_n: 1'b0};
						next_r.st = audio_ctrl_pkg::ST_ACK_WRITE;
						next_r.byte_hi = ~r.byte_hi;
						if (r.byte_hi) begin
							next_r.wr_hi = r.shift;
						end else begin
							wr_en = 1'b1;
							next_r.ptr = r.ptr + 8'h01;
						end
					end
				end
				audio_ctrl_pkg::ST_READ: begin
					if (scl_fall) begin
						if (r.bit_cnt == 4'h8) begin
							next_r.bit_cnt = 4'h0;
							next_r.pins = '{sda_out: 1'b1, sda_oe_n: 1'b1};
							next_r.st = audio_ctrl_pkg::ST_READ_ACK;
						end else begin
							next_r.tx = {r.tx[14:0], 1'b0};
							next_r.pins.sda_oe_n = next_r.tx[15];
						end
					end
				end
				audio_ctrl_pkg::ST_READ_ACK: begin
					if (scl_rise && sda_s) begin
						next_r.st = audio_ctrl_pkg::ST_IDLE; // master nack
					end else if (scl_fall) begin
						next_r.bit_cnt = 4'h0;
						next_r.st = audio_ctrl_pkg::ST_READ;
						next_r.byte_hi = ~r.byte_hi;
						if (r.byte_hi) begin
							next_r.tx = {r.tx[14:0], 1'b0};
						end else begin
							next_r.ptr = r.ptr + 8'h01;
							next_r.tx = read_word(next_r.ptr, r.ctrl, r.volume);
						end
						next_r.pins.sda_out = 1'b0;
						next_r.pins.sda_oe_n = next_r.tx[15];
					end
				end
			endcase
		end

		// mute default follows the mode strap once it has settled
		if (r.boot_cnt != 2'h3) begin
			next_r.boot_cnt = r.boot_cnt + 2'h1;
			if (r.boot_cnt == audio_ctrl_pkg::STRAP_SETTLE) begin
				next_r.ctrl[audio_ctrl_pkg::SOFT_MUTE_BIT] = mode_s;
			end
		end

		if (wr_en) begin
			if (r.ptr == audio_ctrl_pkg::INTERP_CTRL_ADDR) begin
				next_r.ctrl = wr_data[audio_ctrl_pkg::CTRL_USED_MSB:0];
			end else if (r.ptr == audio_ctrl_pkg::VOLUME_ADDR) begin
				next_r.volume = wr_data;
			end
		end

		// ramp walks one table step per divider period toward the target
		next_r.ramp_div = r.ramp_div + 16'h0001;
		if (r.ramp_div >= RAMP_LAST) begin
			next_r.ramp_div = 16'h0000;
			if (r.ctrl[audio_ctrl_pkg::SOFT_MUTE_BIT]) begin
				if (r.ramp_idx < audio_ctrl_pkg::RAMP_STEPS) begin
					next_r.ramp_idx = r.ramp_idx + 5'h01;
				end
			end else if (r.ramp_idx != 5'h00) begin
				next_r.ramp_idx = r.ramp_idx - 5'h01;
			end
		end

		// settings are registered copies of the fields, plus the ramp's muted flag and gain
		next_r.out.channel_polarity_invert =
			next_r.ctrl[audio_ctrl_pkg::POLARITY_BIT];
		next_r.out.filter_rolloff_select = next_r.ctrl[
			audio_ctrl_pkg::ROLLOFF_MSB:audio_ctrl_pkg::ROLLOFF_LSB];
		next_r.out.rolloff_fast =
			next_r.ctrl[audio_ctrl_pkg::ROLLOFF_MSB];
		next_r.out.deemphasis_select = decode_deemph(next_r.ctrl[
			audio_ctrl_pkg::DEEMPH_MSB:audio_ctrl_pkg::DEEMPH_LSB]);
		next_r.out.soft_mute = next_r.ctrl[audio_ctrl_pkg::SOFT_MUTE_BIT];
		next_r.out.muted = next_r.ramp_idx == audio_ctrl_pkg::RAMP_STEPS;
		next_r.out.mute_gain = cosine_gain(next_r.ramp_idx);
		next_r.out.left_volume_code = next_r.volume[
			audio_ctrl_pkg::LEFT_VOL_MSB:audio_ctrl_pkg::LEFT_VOL_LSB];
		next_r.out.right_volume_code = next_r.volume[
			audio_ctrl_pkg::RIGHT_VOL_MSB:audio_ctrl_pkg::RIGHT_VOL_LSB];
	end

	// reset loads legacy defaults; the strap adjusts mute afterwards
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.st <= audio_ctrl_pkg::ST_IDLE;
			r.pins <= '{sda_out: 1'b1, sda_oe_n: 1'b1};
			r.ctrl <= audio_ctrl_pkg::CTRL_RESET_LEGACY[6:0];
			r.volume <= audio_ctrl_pkg::VOLUME_RESET;
			r.out.filter_rolloff_select <= 2'h2;
			r.out.rolloff_fast <= 1'b1;
			r.out.mute_gain <= 8'hff;
		end else begin
			r <= next_r;
		end
	end

	assign bus_out = r.pins;
	assign settings = r.out;
endmodule

// ---- sound_ctrl_props.sv ----
// assertions on the ports of the sound-path control registers
`timescale 1ns/100ps
module sound_ctrl_props #(
	parameter int RAMP_STEP_CYCLES = 4
) (
	input wire logic clock,
	input wire logic nrst,
	input audio_ctrl_pkg::bus_pins_in_s bus_in,
	input wire logic [1:0] addr_select,
	input wire logic i2c_mode,
	input audio_ctrl_pkg::bus_pins_out_s bus_out,
	input audio_ctrl_pkg::sound_settings_s settings
);
	// the ramp must take real time, not jump straight to silence
	localparam int RAMP_MIN = 8 * RAMP_STEP_CYCLES;
	localparam int RAMP_MAX = 16 * RAMP_STEP_CYCLES + 40;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	rolloff_speed_a: assert property (
		settings.rolloff_fast == settings.filter_rolloff_select[1])
		else $error("rolloff speed does not follow its code");
	deemph_range_a: assert property (
		settings.deemphasis_select <= audio_ctrl_pkg::DEEMPH_96K)
		else $error("deemphasis select out of range");
	reset_values_a: assert property ($rose(nrst) |->
		settings.filter_rolloff_select == 2'h2 &&
		!settings.channel_polarity_invert && settings.left_volume_code == 8'h00)
		else $error("settings wrong after reset");
	strap_mute_a: assert property ($rose(nrst) |->
		##[1:5] settings.soft_mute == i2c_mode)
		else $error("soft mute not taken from mode strap");
	ack_drive_a: assert property (!bus_out.sda_oe_n |-> !bus_out.sda_out)
		else $error("data pin driven high");
	volume_commit_a: assert property (($changed(settings.left_volume_code) ||
		$changed(settings.right_volume_code)) |-> !bus_in.scl)
		else $error("volume changed outside a byte ack");
	polarity_commit_a: assert property (
		$changed(settings.channel_polarity_invert) |-> !bus_in.scl)
		else $error("polarity changed outside a byte ack");
	mute_ramp_a: assert property ($rose(settings.soft_mute) |->
		##[RAMP_MIN:RAMP_MAX] settings.muted)
		else $error("mute ramp length wrong");
	muted_gain_a: assert property (settings.muted |->
		settings.mute_gain == 8'h00)
		else $error("gain not zero while muted");
endmodule
bind sound_ctrl_regs sound_ctrl_props #(.RAMP_STEP_CYCLES(RAMP_STEP_CYCLES))
	props (.clock(clock), .nrst(nrst), .bus_in(bus_in), .bus_out(bus_out),
	.addr_select(addr_select), .i2c_mode(i2c_mode), .settings(settings));

// ---- bus_host_model.sv ----
// serial bus host that writes and reads the control registers
`timescale 1ns/100ps
module bus_host_model (
	input wire logic clock,
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// one phase of 8 clocks keeps scl high and low well above 100 ns
	task automatic tick();
		repeat (8) @(posedge clock);
		#2;
	endtask
	// data changes only with scl low and is sampled at the end of high
	task automatic bit_x(input logic b, output logic r);
		sda = b;
		tick();
		scl = 1'b1;
		tick();
		r = sda_line;
		scl = 1'b0;
		tick();
	endtask
	task automatic byte_x(input logic [7:0] tx, input logic ai,
		output logic [7:0] rx, output logic ao);
		for (int i = 7; i >= 0; i--)
			bit_x(tx[i], rx[i]);
		bit_x(ai, ao);
	endtask
	task automatic start();
		sda = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda = 1'b0; // falls while scl high
		tick();
		scl = 1'b0;
		tick();
	endtask
	task automatic stop();
		sda = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda = 1'b1;
		tick();
	endtask
	// n words from ptr, high byte first; ack low means every byte taken
	task automatic write(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [31:0] w, input int n, output logic ack);
		logic [7:0] rx;
		logic a;
		start();
		byte_x({dev, 1'b0}, 1'b1, rx, ack);
		byte_x(ptr, 1'b1, rx, a);
		ack = ack | a;
		for (int i = n * 2 - 1; i >= 0; i--) begin
			byte_x(w[i*8 +: 8], 1'b1, rx, a);
			ack = ack | a;
		end
		stop();
	endtask
	task automatic read(input logic [6:0] dev, input logic [7:0] ptr,
		input int n, output logic [31:0] w);
		logic [7:0] rx;
		logic a;
		start();
		byte_x({dev, 1'b0}, 1'b1, rx, a);
		byte_x(ptr, 1'b1, rx, a);
		start();
		byte_x({dev, 1'b1}, 1'b1, rx, a);
		w = '0;
		for (int i = n * 2 - 1; i >= 0; i--) begin
			byte_x(8'hff, i == 0, rx, a); // nack on the last byte ends it
			w[i*8 +: 8] = rx;
		end
		stop();
	endtask
endmodule

// ---- sound_ctrl_regs_test.sv ----
// self-checking bench for the sound-path control registers
`timescale 1ns/100ps
module sound_ctrl_regs_test;
	localparam logic [6:0] DEV = {audio_ctrl_pkg::DEVICE_ADDR_BASE, 2'h1};
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic i2c_mode = 1'b1;
	logic scl;
	logic sda;
	wire sda_line;
	int miscompares = 0;
	int num_checks = 0;
	audio_ctrl_pkg::bus_pins_out_s bus_out;
	audio_ctrl_pkg::sound_settings_s st;
	// pulled-up wire, low whenever either side pulls it
	assign sda_line = sda & (bus_out.sda_oe_n | bus_out.sda_out);
	initial begin
		forever #12.5 clock = ~clock;
	end
	sound_ctrl_regs #(.RAMP_STEP_CYCLES(4)) DUT (.clock(clock), .nrst(nrst),
		.bus_in({scl, sda_line}), .addr_select(2'h1), .i2c_mode(i2c_mode),
		.bus_out(bus_out), .settings(st));
	bus_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl),
		.sda(sda));
	task automatic chk(input string name, input logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset(input logic mode);
		i2c_mode = mode;
		nrst = 1'b0;
		repeat (8) @(posedge clock);
		#2 nrst = 1'b1;
		repeat (6) @(posedge clock);
		#2;
	endtask
	task automatic t_reset(input logic [15:0] e);
		logic [31:0] w;
		host.read(DEV, 8'h00, 2, w);
		chk("ctrl reset", e, w[31:16]);
		chk("volume reset", 16'h0000, w[15:0]);
		chk("mute reset", {15'h0, e[0]}, {15'h0, st.soft_mute});
	endtask
	// every deemphasis code, with reserved bits written as ones
	task automatic t_fields();
		logic [15:0] v;
		logic [31:0] w;
		logic a;
		for (int c = 0; c < 8; c++) begin
			v = {9'h1ff, c[0], c[1:0], c[2:0], 1'b0};
			host.write(DEV, 8'h00, {16'h0, v}, 1, a);
			chk("ctrl ack", 16'h0, {15'h0, a});
			chk("polarity", {15'h0, c[0]}, {15'h0, st.channel_polarity_invert});
			chk("rolloff", {14'h0, c[1:0]}, {14'h0, st.filter_rolloff_select});
			chk("rolloff fast", {15'h0, c[1]}, {15'h0, st.rolloff_fast});
			chk("deemph", {13'h0, c < 5 ? c[2:0] : 3'h0},
				{13'h0, st.deemphasis_select});
			host.read(DEV, 8'h00, 1, w);
			chk("ctrl readback", {9'h0, v[6:0]}, w[15:0]);
		end
	endtask
	// two words back to back, pointer stepping from ctrl to volume
	task automatic t_volume();
		logic [31:0] w;
		logic a;
		host.write(DEV, 8'h00, 32'h0040a55a, 2, a);
		chk("left code", 16'h00a5, {8'h0, st.left_volume_code});
		chk("right code", 16'h005a, {8'h0, st.right_volume_code});
		host.read(DEV, 8'h00, 2, w);
		chk("pair readback", 16'h0040, w[31:16]);
		chk("volume readback", 16'ha55a, w[15:0]);
	endtask
	// wrong slave address is ignored; an unmapped pointer reads zero
	task automatic t_refuse();
		logic [31:0] w;
		logic a;
		host.write(DEV ^ 7'h01, 8'h01, 32'h1234, 1, a);
		chk("foreign ack", 16'h1, {15'h0, a});
		host.write(DEV, 8'h05, 32'hffff, 1, a);
		chk("unmapped ack", 16'h0, {15'h0, a});
		host.read(DEV, 8'h05, 1, w);
		chk("unmapped read", 16'h0, w[15:0]);
		host.read(DEV, 8'h01, 1, w);
		chk("volume kept", 16'ha55a, w[15:0]);
	endtask
	// mute down to silence, then back up to full gain
	task automatic t_mute();
		logic a;
		host.write(DEV, 8'h00, 32'h0001, 1, a);
		for (int i = 0; i < 200 && st.muted !== 1'b1; i++)
			@(posedge clock);
		#2;
		chk("muted", 16'h1, {15'h0, st.muted});
		chk("muted gain", 16'h0, {8'h0, st.mute_gain});
		chk("mute bit", 16'h1, {15'h0, st.soft_mute});
		host.write(DEV, 8'h00, 32'h0000, 1, a);
		for (int i = 0; i < 200 && st.mute_gain !== 8'hff; i++)
			@(posedge clock);
		#2;
		chk("unmuted", 16'h0, {15'h0, st.muted});
		chk("full gain", 16'h00ff, {8'h0, st.mute_gain});
		chk("unmute bit", 16'h0, {15'h0, st.soft_mute});
	endtask
	initial begin
		do_reset(1'b1);
		t_reset(16'h0021);
		t_fields();
		t_volume();
		t_refuse();
		t_mute();
		do_reset(1'b0);
		t_reset(16'h0020);
		summarize();
	end
	// the whole sequence needs about 29k clocks
	initial begin
		repeat (90000) @(posedge clock);
		miscompares++;
		summarize();
	end
endmodule
